/* src/ust_defines.svh */
// Offsets, field positions, reset values and baud-tick counts of the status and timing sequencer.
// Assumes inclusion by bare name from every file that needs them.
`ifndef UST_DEFINES_SVH
`define UST_DEFINES_SVH
`define UST_ADDR_TXDATA 8'h00
`define UST_ADDR_RXDATA 8'h04
`define UST_ADDR_STATUS 8'h08
`define UST_ADDR_BAUD 8'h0c
`define UST_ADDR_CTRL 8'h10
`define UST_ADDR_PEND 8'h14
`define UST_ADDR_MASK 8'h18
`define UST_BAUD_CLKSEL 7
`define UST_CTRL_GIE 0
`define UST_CTRL_MIE 1
`define UST_CTRL_RTS 2
`define UST_CTRL_DTR 3
`define UST_CTRL_PAREN 4
`define UST_CTRL_PARODD 5
`define UST_BAUD_RESET 8'h00
`define UST_CTRL_RESET 8'h00
`define UST_MASK_RESET 8'h00
`define UST_TICK_TX_BUFFER_EMPTY 5'h04
`define UST_TICK_START 5'h05
`define UST_TICK_SAMPLE 5'h08
`define UST_TICK_FLAGS 5'h0b
`define UST_TICK_LATE_WR 5'h0c
`define UST_TICK_RELOAD 5'h0f
`define UST_TICK_BIT 5'h10
`define UST_LAST_BIT_PAR 4'ha
`define UST_LAST_BIT 4'h9
`define UST_RESP_OKAY 2'h0
`define UST_RESP_SLVERR 2'h2
`endif

/* src/ust_pkg.sv */
// Types shared by the status and timing sequencer modules.
// Assumes the defines header supplies every numeric constant.
package ust_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_WAIT = 2'b01,
		TX_SHIFT = 2'b10
	} ust_tx_state_t;
	typedef enum logic [0:0] {
		RX_IDLE = 1'b0,
		RX_BITS = 1'b1
	} ust_rx_state_t;
	typedef struct packed {
		logic dr;
		logic tx_buffer_empty;
		logic tc;
		logic ms;
		logic brk;
		logic oe;
		logic fe;
		logic pe;
	} ust_status_t;
endpackage

/* src/ust_sync.sv */
// Three-stage pin synchroniser with agreement filter.
// Assumes an asynchronous input; output changes once stages two and three agree.
`timescale 1ns/1ps
module ust_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic pinIn,
	output logic syncOut
);
	logic s1_q, s2_q, s3_q, out_q, out_d;

	always_comb begin
		out_d = (s2_q == s3_q) ? s3_q : out_q;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s1_q <= RESET_VAL;
			s2_q <= RESET_VAL;
			s3_q <= RESET_VAL;
			out_q <= RESET_VAL;
		end else begin
			s1_q <= pinIn;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= out_d;
		end
	end

	assign syncOut = out_q;
endmodule

/* src/ust_baud_gen.sv */
// Baud generator: a 16x bit-rate clock divided from the core clock.
// Assumes divisor is the low seven bits of the baud select register.
`timescale 1ns/1ps
module ust_baud_gen (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [6:0] divisor,
	output logic baudClk,
	output logic baudTick
);
	logic [6:0] cnt_q, cnt_d;
	logic clk_q, clk_d, tick_q, tick_d;

	// Each half period lasts divisor+1 core cycles; the tick marks the falling edge.
	always_comb begin
		cnt_d = cnt_q + 7'h01;
		clk_d = clk_q;
		tick_d = 1'b0;
		if (cnt_q >= divisor) begin
			cnt_d = 7'h00;
			clk_d = !clk_q;
			tick_d = clk_q;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 7'h00;
			clk_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			clk_q <= clk_d;
			tick_q <= tick_d;
		end
	end

	assign baudClk = clk_q;
	assign baudTick = tick_q;
endmodule

/* src/ust_top.sv */
// UART transmit, receive, status and interrupt sequencing timed in 16x baud ticks.
// Assumes an AXI4-Lite master on core_clk and asynchronous serial and modem pins.
// Functional notes
// - Select bit low: clock output copies oscillator
// - Select bit high: clock output is baud clock
// - Idle shifter: start bit at fifth tick
// - Busy shifter: next frame after sixteenth tick
// - Write clears buffer-empty; set at fourth tick
// - Busy shifter: buffer-empty at fifteenth tick
// - Clear-to-send high holds off transmission
// - Status bit six mirrors buffer-empty
// - Transmit complete at eleventh stop tick
// - Receive errors update at eleventh stop tick
// - Modem line change sets modem status
// - Data ready at eleventh stop tick
// - Status bit seven mirrors data ready
// - Modem control write drives RTS and DTR
`timescale 1ns/1ps
`include "ust_defines.svh"
module ust_top (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic oscIn,
	input wire logic serialIn,
	input wire logic clearToSendN,
	input wire logic dataSetReadyN,
	output logic clockOut,
	output logic serialOut,
	output logic txBufferEmpty,
	output logic rxDataReady,
	output logic irqOut,
	output logic requestToSendN,
	output logic dataTermReadyN
);
	import ust_pkg::*;

	logic oscSync, rxSync, ctsSync, dsrSync, baudClk, baudTick;
	ust_sync #(.RESET_VAL(1'b0)) uOsc (.core_clk(core_clk), .rst(rst), .pinIn(oscIn),
		.syncOut(oscSync));
	ust_sync #(.RESET_VAL(1'b1)) uRx (.core_clk(core_clk), .rst(rst), .pinIn(serialIn),
		.syncOut(rxSync));
	ust_sync #(.RESET_VAL(1'b1)) uCts (.core_clk(core_clk), .rst(rst), .pinIn(clearToSendN),
		.syncOut(ctsSync));
	ust_sync #(.RESET_VAL(1'b1)) uDsr (.core_clk(core_clk), .rst(rst), .pinIn(dataSetReadyN),
		.syncOut(dsrSync));

	logic [7:0] baud_q, baud_d, ctrl_q, ctrl_d, mask_q, mask_d;
	ust_baud_gen uBaud (.core_clk(core_clk), .rst(rst), .divisor(baud_q[6:0]),
		.baudClk(baudClk), .baudTick(baudTick));

	// Register bus.
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d, awRdy_q, awRdy_d, wRdy_q, wRdy_d;
	logic bValid_q, bValid_d, arRdy_q, arRdy_d, rValid_q, rValid_d;
	logic [7:0] awAddr_q, awAddr_d;
	logic [7:0] wData_q, wData_d;
	logic wLane_q, wLane_d;
	logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
	logic [31:0] rData_q, rData_d;
	logic doWrite, wrTx, wrPend, rxRead, statusRead, awMapped, arMapped;
	ust_status_t status, pend_q, pend_d;
	logic [7:0] rxBuf_q, rxBuf_d;

	always_comb begin
		awHeld_d = awHeld_q | (s_axi_awvalid & awRdy_q);
		wHeld_d = wHeld_q | (s_axi_wvalid & wRdy_q);
		awAddr_d = (s_axi_awvalid & awRdy_q) ? s_axi_awaddr : awAddr_q;
		wData_d = (s_axi_wvalid & wRdy_q) ? s_axi_wdata[7:0] : wData_q;
		wLane_d = (s_axi_wvalid & wRdy_q) ? s_axi_wstrb[0] : wLane_q;
		bValid_d = bValid_q & !s_axi_bready;
		bResp_d = bResp_q;
		awMapped = awAddr_q == `UST_ADDR_TXDATA || awAddr_q == `UST_ADDR_BAUD
			|| awAddr_q == `UST_ADDR_CTRL || awAddr_q == `UST_ADDR_PEND
			|| awAddr_q == `UST_ADDR_MASK;
		doWrite = awHeld_q & wHeld_q & !bValid_q;
		baud_d = baud_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		if (doWrite) begin
			awHeld_d = 1'b0;
			wHeld_d = 1'b0;
			bValid_d = 1'b1;
			bResp_d = awMapped ? `UST_RESP_OKAY : `UST_RESP_SLVERR;
			if (wLane_q && awAddr_q == `UST_ADDR_BAUD) begin
				baud_d = wData_q;
			end
			if (wLane_q && awAddr_q == `UST_ADDR_CTRL) begin
				ctrl_d = wData_q;
			end
			if (wLane_q && awAddr_q == `UST_ADDR_MASK) begin
				mask_d = wData_q;
			end
		end
		wrTx = doWrite & wLane_q & (awAddr_q == `UST_ADDR_TXDATA);
		wrPend = doWrite & wLane_q & (awAddr_q == `UST_ADDR_PEND);
		awRdy_d = !awHeld_d & !bValid_d;
		wRdy_d = !wHeld_d & !bValid_d;
		arMapped = s_axi_araddr == `UST_ADDR_RXDATA || s_axi_araddr == `UST_ADDR_STATUS
			|| s_axi_araddr == `UST_ADDR_BAUD || s_axi_araddr == `UST_ADDR_CTRL
			|| s_axi_araddr == `UST_ADDR_PEND || s_axi_araddr == `UST_ADDR_MASK;
		rValid_d = rValid_q & !s_axi_rready;
		rData_d = rData_q;
		rResp_d = rResp_q;
		rxRead = 1'b0;
		statusRead = 1'b0;
		if (s_axi_arvalid && arRdy_q) begin
			rValid_d = 1'b1;
			rResp_d = arMapped ? `UST_RESP_OKAY : `UST_RESP_SLVERR;
			rxRead = s_axi_araddr == `UST_ADDR_RXDATA;
			statusRead = s_axi_araddr == `UST_ADDR_STATUS;
			case (s_axi_araddr)
				`UST_ADDR_RXDATA: rData_d = {24'h000000, rxBuf_q};
				`UST_ADDR_STATUS: rData_d = {24'h000000, status};
				`UST_ADDR_BAUD: rData_d = {24'h000000, baud_q};
				`UST_ADDR_CTRL: rData_d = {24'h000000, ctrl_q};
				`UST_ADDR_PEND: rData_d = {24'h000000, pend_q};
				`UST_ADDR_MASK: rData_d = {24'h000000, mask_q};
				default: rData_d = 32'h00000000;
			endcase
		end
		arRdy_d = !rValid_d;
	end

	// Transmitter.
	ust_tx_state_t txState_q, txState_d;
	logic [4:0] txCnt_q, txCnt_d, txInc;
	logic [3:0] txBit_q, txBit_d, lastBit;
	logic [10:0] shift_q, shift_d, nextFrame;
	logic [7:0] hold_q, hold_d;
	logic holdFull_q, holdFull_d, queued_q, queued_d, serOut_q, serOut_d, tcSet;
	logic ctsHigh;

	assign ctsHigh = ctsSync;
	assign lastBit = ctrl_q[`UST_CTRL_PAREN] ? `UST_LAST_BIT_PAR : `UST_LAST_BIT;
	assign nextFrame = ctrl_q[`UST_CTRL_PAREN]
		? {1'b1, (^hold_q) ^ ctrl_q[`UST_CTRL_PARODD], hold_q, 1'b0}
		: {2'b11, hold_q, 1'b0};
	assign txInc = txCnt_q + 5'h01;

	always_comb begin
		txState_d = txState_q;
		txCnt_d = txCnt_q;
		txBit_d = txBit_q;
		shift_d = shift_q;
		hold_d = wrTx ? wData_q : hold_q;
		holdFull_d = holdFull_q | wrTx;
		queued_d = queued_q;
		serOut_d = serOut_q;
		tcSet = 1'b0;
		case (txState_q)
			TX_IDLE: begin
				if (holdFull_q && !ctsHigh) begin
					txState_d = TX_WAIT;
					txCnt_d = 5'h00;
				end
			end
			TX_WAIT: begin
				if (ctsHigh && txCnt_q < `UST_TICK_TX_BUFFER_EMPTY) begin
					txState_d = TX_IDLE;
				end else if (baudTick) begin
					txCnt_d = txInc;
					if (txInc == `UST_TICK_TX_BUFFER_EMPTY) begin
						shift_d = nextFrame;
						holdFull_d = wrTx;
					end
					if (txInc == `UST_TICK_START) begin
						txState_d = TX_SHIFT;
						txCnt_d = 5'h00;
						txBit_d = 4'h0;
						serOut_d = shift_q[0];
					end
				end
			end
			TX_SHIFT: begin
				if (baudTick) begin
					txCnt_d = txInc;
					if (txBit_q == lastBit && txInc == `UST_TICK_FLAGS) begin
						tcSet = !holdFull_q;
					end
					if (txBit_q == lastBit && txInc == `UST_TICK_LATE_WR) begin
						queued_d = holdFull_q & !ctsHigh;
					end
					if (txBit_q == lastBit && txInc == `UST_TICK_RELOAD && queued_q) begin
						shift_d = nextFrame;
						holdFull_d = wrTx;
					end
					if (txInc == `UST_TICK_BIT) begin
						txCnt_d = 5'h00;
						if (txBit_q != lastBit) begin
							txBit_d = txBit_q + 4'h1;
							serOut_d = shift_q[txBit_q + 4'h1];
						end else if (queued_q) begin
							txBit_d = 4'h0;
							serOut_d = shift_q[0];
							queued_d = 1'b0;
						end else begin
							txState_d = TX_IDLE;
							serOut_d = 1'b1;
						end
					end
				end
			end
			default: txState_d = TX_IDLE;
		endcase
	end

	// Receiver.
	ust_rx_state_t rxState_q, rxState_d;
	logic [4:0] rxCnt_q, rxCnt_d, rxInc;
	logic [3:0] rxBit_q, rxBit_d;
	logic [10:0] rxShift_q, rxShift_d;
	logic rxDone, rxPar;

	assign rxInc = rxCnt_q + 5'h01;
	assign rxPar = ^rxShift_q[9:1] ^ ctrl_q[`UST_CTRL_PARODD];

	always_comb begin
		rxState_d = rxState_q;
		rxCnt_d = rxCnt_q;
		rxBit_d = rxBit_q;
		rxShift_d = rxShift_q;
		rxDone = 1'b0;
		case (rxState_q)
			RX_IDLE: begin
				if (!rxSync) begin
					rxState_d = RX_BITS;
					rxCnt_d = 5'h00;
					rxBit_d = 4'h0;
				end
			end
			RX_BITS: begin
				if (baudTick) begin
					rxCnt_d = rxInc;
					if (rxInc == `UST_TICK_SAMPLE) begin
						rxShift_d[rxBit_q] = rxSync;
						if (rxBit_q == 4'h0 && rxSync) begin
							rxState_d = RX_IDLE;
						end
					end
					if (rxBit_q == lastBit && rxInc == `UST_TICK_FLAGS) begin
						rxDone = 1'b1;
						rxState_d = RX_IDLE;
					end else if (rxInc == `UST_TICK_BIT) begin
						rxCnt_d = 5'h00;
						rxBit_d = rxBit_q + 4'h1;
					end
				end
			end
			default: rxState_d = RX_IDLE;
		endcase
	end

	// Status, interrupts and modem lines.
	ust_status_t ev, sticky_q, sticky_d, ack;
	logic dr_q, dr_d, tx_buffer_empty_q, tx_buffer_empty_d, irq_q, irq_d, clk_q, clk_d, ctsOld_q, dsrOld_q;
	logic rtsN_q, dtrN_q, stopBit;

	assign stopBit = rxShift_q[lastBit];
	assign status = {dr_q, tx_buffer_empty_q, sticky_q[5:0]};

	always_comb begin
		ev = '0;
		ev.tx_buffer_empty = holdFull_q & !holdFull_d;
		ev.tc = tcSet;
		ev.ms = (ctsSync != ctsOld_q) | (dsrSync != dsrOld_q);
		ev.dr = rxDone;
		ev.brk = rxDone & (rxShift_q[8:0] == 9'h000) & !stopBit;
		ev.oe = rxDone & dr_q & !rxRead;
		ev.fe = rxDone & !stopBit;
		ev.pe = rxDone & ctrl_q[`UST_CTRL_PAREN] & rxPar;
		ack = statusRead ? 8'hff : 8'h00;
		sticky_d = (sticky_q & ~ack) | ev;
		pend_d = (pend_q & ~ack & ~(wrPend ? wData_q : 8'h00)) | ev;
		dr_d = rxDone | (dr_q & !rxRead);
		rxBuf_d = rxDone ? rxShift_q[8:1] : rxBuf_q;
		tx_buffer_empty_d = !holdFull_d;
		irq_d = ctrl_q[`UST_CTRL_GIE] & |(pend_d & mask_q
			& {3'b111, ctrl_q[`UST_CTRL_MIE], 4'hf});
		clk_d = baud_q[`UST_BAUD_CLKSEL] ? baudClk : oscSync;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			awRdy_q <= 1'b0;
			wRdy_q <= 1'b0;
			bValid_q <= 1'b0;
			arRdy_q <= 1'b0;
			rValid_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 8'h00;
			wLane_q <= 1'b0;
			bResp_q <= 2'h0;
			rResp_q <= 2'h0;
			rData_q <= 32'h00000000;
			baud_q <= `UST_BAUD_RESET;
			ctrl_q <= `UST_CTRL_RESET;
			mask_q <= `UST_MASK_RESET;
			txState_q <= TX_IDLE;
			txCnt_q <= 5'h00;
			txBit_q <= 4'h0;
			shift_q <= 11'h7ff;
			hold_q <= 8'h00;
			holdFull_q <= 1'b0;
			queued_q <= 1'b0;
			serOut_q <= 1'b1;
			rxState_q <= RX_IDLE;
			rxCnt_q <= 5'h00;
			rxBit_q <= 4'h0;
			rxShift_q <= 11'h000;
			rxBuf_q <= 8'h00;
			sticky_q <= '0;
			pend_q <= '0;
			dr_q <= 1'b0;
			tx_buffer_empty_q <= 1'b1;
			irq_q <= 1'b0;
			clk_q <= 1'b0;
			ctsOld_q <= 1'b1;
			dsrOld_q <= 1'b1;
			rtsN_q <= 1'b1;
			dtrN_q <= 1'b1;
		end else begin
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			awRdy_q <= awRdy_d;
			wRdy_q <= wRdy_d;
			bValid_q <= bValid_d;
			arRdy_q <= arRdy_d;
			rValid_q <= rValid_d;
			awAddr_q <= awAddr_d;
			wData_q <= wData_d;
			wLane_q <= wLane_d;
			bResp_q <= bResp_d;
			rResp_q <= rResp_d;
			rData_q <= rData_d;
			baud_q <= baud_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			txState_q <= txState_d;
			txCnt_q <= txCnt_d;
			txBit_q <= txBit_d;
			shift_q <= shift_d;
			hold_q <= hold_d;
			holdFull_q <= holdFull_d;
			queued_q <= queued_d;
			serOut_q <= serOut_d;
			rxState_q <= rxState_d;
			rxCnt_q <= rxCnt_d;
			rxBit_q <= rxBit_d;
			rxShift_q <= rxShift_d;
			rxBuf_q <= rxBuf_d;
			sticky_q <= sticky_d;
			pend_q <= pend_d;
			dr_q <= dr_d;
			tx_buffer_empty_q <= tx_buffer_empty_d;
			irq_q <= irq_d;
			clk_q <= clk_d;
			ctsOld_q <= ctsSync;
			dsrOld_q <= dsrSync;
			rtsN_q <= !ctrl_d[`UST_CTRL_RTS];
			dtrN_q <= !ctrl_d[`UST_CTRL_DTR];
		end
	end

	assign s_axi_awready = awRdy_q;
	assign s_axi_wready = wRdy_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_arready = arRdy_q;
	assign s_axi_rvalid = rValid_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign clockOut = clk_q;
	assign serialOut = serOut_q;
	assign txBufferEmpty = tx_buffer_empty_q;
	assign rxDataReady = dr_q;
	assign irqOut = irq_q;
	assign requestToSendN = rtsN_q;
	assign dataTermReadyN = dtrN_q;

	clk_osc_a: assert property (@(posedge core_clk) disable iff (rst)
		!baud_q[`UST_BAUD_CLKSEL] |=> clockOut == $past(oscSync))
		else $error("clock output not the oscillator copy");
	clk_brg_a: assert property (@(posedge core_clk) disable iff (rst)
		baud_q[`UST_BAUD_CLKSEL] |=> clockOut == $past(baudClk))
		else $error("clock output not the baud clock");
	tx_start_a: assert property (@(posedge core_clk) disable iff (rst)
		txState_q == TX_WAIT && baudTick && txInc == `UST_TICK_START |=>
		txState_q == TX_SHIFT && !serialOut)
		else $error("start bit not sent at fifth tick");
	tx_buffer_empty_wait_a: assert property (@(posedge core_clk) disable iff (rst)
		txState_q == TX_WAIT && baudTick && txInc == `UST_TICK_TX_BUFFER_EMPTY && !ctsHigh && !wrTx
		|=> txBufferEmpty ##1 (txBufferEmpty || $past(wrTx)))
		else $error("buffer empty not set at fourth tick");
	tx_buffer_empty_clear_a: assert property (@(posedge core_clk) disable iff (rst)
		wrTx |=> !txBufferEmpty)
		else $error("write did not clear buffer empty");
	cts_hold_a: assert property (@(posedge core_clk) disable iff (rst)
		txState_q == TX_IDLE && ctsHigh |=> txState_q == TX_IDLE)
		else $error("transmission began while clear-to-send high");
	stat_mirror_a: assert property (@(posedge core_clk) disable iff (rst)
		statusRead |=> s_axi_rdata[7:6] == $past({dr_q, tx_buffer_empty_q}))
		else $error("status bits do not mirror ready flags");
	irq_gate_a: assert property (@(posedge core_clk) disable iff (rst)
		irqOut |-> $past(ctrl_q[`UST_CTRL_GIE]))
		else $error("interrupt raised while disabled");
	dr_read_a: assert property (@(posedge core_clk) disable iff (rst)
		rxRead && !rxDone |=> !rxDataReady)
		else $error("receive read did not clear data ready");
	ack_drop_a: assert property (@(posedge core_clk) disable iff (rst)
		statusRead && ev == 8'h00 |=> !irqOut)
		else $error("acknowledging read left interrupt high");
endmodule

/* dv/ust_line_model.sv */
// Far end of the serial link: decodes the transmit pin and drives the receive and modem pins.
// Assumes 8 data bits, no parity, one stop bit and a fixed count of core cycles per bit.
`timescale 1ns/1ps
module ust_line_model #(
	parameter int BIT_CYCLES = 32
) (
	input wire logic core_clk,
	input wire logic serialOut,
	output logic serialIn,
	output logic clearToSendN,
	output logic dataSetReadyN,
	output logic [7:0] rxByte,
	output logic rxStop,
	output int rxCount
);
	initial begin
		serialIn = 1'b1;
		{clearToSendN, dataSetReadyN} = 2'h3;
		{rxByte, rxStop} = 9'h000;
		rxCount = 0;
	end
	// Each bit is taken in its middle, so a late or early edge of one core cycle goes unseen.
	always begin
		@(negedge serialOut);
		repeat (BIT_CYCLES / 2) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYCLES) @(posedge core_clk);
			rxByte[i] = serialOut;
		end
		repeat (BIT_CYCLES) @(posedge core_clk);
		rxStop = serialOut;
		rxCount++;
	end
	task automatic send_char(input logic [7:0] data, input logic stopBit);
		logic [9:0] frame;
		frame = {stopBit, data, 1'b0};
		for (int i = 0; i < 10; i++) begin
			serialIn <= frame[i];
			repeat (BIT_CYCLES) @(posedge core_clk);
		end
		serialIn <= 1'b1;
	endtask
	// Only called while the link is idle, so clear-to-send never moves near a stop bit.
	task automatic set_lines(input logic cts, input logic dsr);
		clearToSendN <= cts;
		dataSetReadyN <= dsr;
	endtask
endmodule

/* dv/ust_top_tb_top.sv */
// Self-checking bench for the UART status and timing sequencer.
// Assumes the line model on the far pins and divisor zero, so a bit lasts 32 core cycles.
`timescale 1ns/1ps
`include "ust_defines.svh"
module ust_top_tb_top;
	import ust_pkg::*;
	localparam int BIT = 32;
	logic core_clk, rst, oscIn, serialIn, clearToSendN, dataSetReadyN, rxStop;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rxByte;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic clockOut, serialOut, txBufferEmpty, rxDataReady, irqOut, requestToSendN, dataTermReadyN;
	int rxCount, failures, comparisons, cycles;
	ust_top i_ust_top (
		.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .oscIn, .serialIn, .clearToSendN, .dataSetReadyN,
		.clockOut, .serialOut, .txBufferEmpty, .rxDataReady, .irqOut, .requestToSendN,
		.dataTermReadyN
	);
	ust_line_model #(.BIT_CYCLES(BIT)) i_ust_line_model (
		.core_clk, .serialOut, .serialIn, .clearToSendN, .dataSetReadyN, .rxByte, .rxStop, .rxCount
	);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic bad;
		bad = addr == `UST_ADDR_RXDATA || addr == `UST_ADDR_STATUS || addr > `UST_ADDR_MASK;
		s_axi_awaddr <= addr;
		s_axi_wdata <= {24'h000000, data};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		check("bresp", 32'(bad ? `UST_RESP_SLVERR : `UST_RESP_OKAY), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] addr, input logic [31:0] exp, input string what);
		logic bad;
		bad = addr == `UST_ADDR_TXDATA || addr > `UST_ADDR_MASK;
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		check("rresp", 32'(bad ? `UST_RESP_SLVERR : `UST_RESP_OKAY), 32'(s_axi_rresp));
		check(what, exp, s_axi_rdata);
	endtask
	// Waits for a start bit that follows a high line, so a start already under way is skipped.
	task automatic measure(output int nE, output int nS);
		logic hi;
		{hi, nE, nS} = {1'b0, -32'sd1, 32'sd0};
		while (!(hi && serialOut === 1'b0)) begin
			if (serialOut === 1'b1) hi = 1'b1;
			@(posedge core_clk);
			nS++;
			if (nE < 0 && txBufferEmpty === 1'b1) nE = nS;
		end
	endtask
	task automatic wait_rx(input int n);
		while (rxCount < n) @(posedge core_clk);
		repeat (BIT) @(posedge core_clk);
	endtask
	task automatic t_reset();
		check("reset pins", 32'h27, 32'({txBufferEmpty, rxDataReady, irqOut, serialOut,
			requestToSendN, dataTermReadyN}));
		i_ust_line_model.set_lines(1'b0, 1'b1);
		repeat (10) @(posedge core_clk);
		rd(`UST_ADDR_STATUS, 32'h50, "status cts fall");
		rd(`UST_ADDR_STATUS, 32'h40, "status cleared");
	endtask
	task automatic t_regs();
		wr(`UST_ADDR_CTRL, 8'h0c);
		repeat (2) @(posedge core_clk);
		check("modem pins on", 32'h0, 32'({requestToSendN, dataTermReadyN}));
		rd(`UST_ADDR_CTRL, 32'h0c, "ctrl");
		wr(`UST_ADDR_CTRL, 8'h08);
		repeat (2) @(posedge core_clk);
		check("modem pins mixed", 32'h2, 32'({requestToSendN, dataTermReadyN}));
		rd(8'h1c, 32'h0, "unmapped");
		wr(`UST_ADDR_STATUS, 8'hff);
		wr(`UST_ADDR_CTRL, 8'h00);
	endtask
	task automatic t_clock();
		logic prev;
		oscIn <= 1'b1;
		repeat (12) @(posedge core_clk);
		check("clock out high", 32'h1, 32'(clockOut));
		oscIn <= 1'b0;
		repeat (12) @(posedge core_clk);
		check("clock out low", 32'h0, 32'(clockOut));
		wr(`UST_ADDR_BAUD, 8'h80);
		repeat (4) @(posedge core_clk);
		prev = clockOut;
		@(posedge core_clk);
		check("clock out toggles", 32'h1, 32'(clockOut ^ prev));
	endtask
	task automatic t_tx_idle();
		int nE, nS;
		wr(`UST_ADDR_TXDATA, 8'h5a);
		check("empty after write", 32'h0, 32'(txBufferEmpty));
		measure(nE, nS);
		check("empty to start", 32'd2, 32'(nS - nE));
		check("empty delay", 32'h1, 32'(nE >= 6 && nE <= 12));
		wait_rx(1);
		check("char one", 32'h15a, 32'({rxStop, rxByte}));
		rd(`UST_ADDR_STATUS, 32'h60, "status complete");
	endtask
	task automatic t_tx_busy();
		int nE, nS, tA;
		wr(`UST_ADDR_MASK, 8'h20);
		wr(`UST_ADDR_CTRL, 8'h01);
		wr(`UST_ADDR_TXDATA, 8'hff);
		measure(nE, nS);
		tA = cycles;
		wr(`UST_ADDR_TXDATA, 8'hc3);
		measure(nE, nS);
		check("frame spacing", 32'd320, 32'(cycles - tA));
		check("empty before start", 32'd2, 32'(nS - nE));
		repeat (BIT * 3) @(posedge core_clk);
		rd(`UST_ADDR_STATUS, 32'h40, "status buffer refilled");
		check("no early irq", 32'h0, 32'(irqOut));
		wait_rx(3);
		check("irq complete", 32'h1, 32'(irqOut));
		rd(`UST_ADDR_STATUS, 32'h60, "status complete");
		repeat (2) @(posedge core_clk);
		check("irq acknowledged", 32'h0, 32'(irqOut));
		check("char three", 32'h1c3, 32'({rxStop, rxByte}));
		wr(`UST_ADDR_CTRL, 8'h00);
	endtask
	task automatic t_cts();
		int nE, nS;
		i_ust_line_model.set_lines(1'b1, 1'b1);
		repeat (10) @(posedge core_clk);
		rd(`UST_ADDR_STATUS, 32'h50, "status cts rise");
		wr(`UST_ADDR_TXDATA, 8'h96);
		repeat (BIT * 4) @(posedge core_clk);
		check("held off", 32'h1, 32'({txBufferEmpty, serialOut}));
		i_ust_line_model.set_lines(1'b0, 1'b1);
		measure(nE, nS);
		check("cts empty to start", 32'd2, 32'(nS - nE));
		check("cts empty delay", 32'h1, 32'(nE >= 8 && nE <= 20));
		wait_rx(4);
		check("char four", 32'h196, 32'({rxStop, rxByte}));
		rd(`UST_ADDR_STATUS, 32'h70, "status after cts");
	endtask
	task automatic t_rx();
		check("ready idle", 32'h0, 32'(rxDataReady));
		i_ust_line_model.send_char(8'ha7, 1'b1);
		check("ready set", 32'h1, 32'(rxDataReady));
		rd(`UST_ADDR_STATUS, 32'hc0, "status ready");
		rd(`UST_ADDR_RXDATA, 32'ha7, "rx data");
		repeat (2) @(posedge core_clk);
		check("ready cleared", 32'h0, 32'(rxDataReady));
		i_ust_line_model.send_char(8'h00, 1'b0);
		rd(`UST_ADDR_STATUS, 32'hca, "status break");
		rd(`UST_ADDR_RXDATA, 32'h00, "rx break data");
		i_ust_line_model.send_char(8'h11, 1'b1);
		i_ust_line_model.send_char(8'h22, 1'b1);
		rd(`UST_ADDR_STATUS, 32'hc4, "status overrun");
		rd(`UST_ADDR_RXDATA, 32'h22, "rx overrun data");
	endtask
	task automatic t_modem();
		wr(`UST_ADDR_MASK, 8'h10);
		wr(`UST_ADDR_CTRL, 8'h01);
		i_ust_line_model.set_lines(1'b0, 1'b0);
		repeat (10) @(posedge core_clk);
		check("irq needs modem enable", 32'h0, 32'(irqOut));
		wr(`UST_ADDR_CTRL, 8'h03);
		repeat (2) @(posedge core_clk);
		check("irq modem", 32'h1, 32'(irqOut));
		rd(`UST_ADDR_PEND, 32'h10, "pend modem");
		rd(`UST_ADDR_STATUS, 32'h50, "status dsr");
		repeat (2) @(posedge core_clk);
		check("irq acknowledged", 32'h0, 32'(irqOut));
		i_ust_line_model.set_lines(1'b0, 1'b1);
		repeat (10) @(posedge core_clk);
		check("irq dsr rise", 32'h1, 32'(irqOut));
		wr(`UST_ADDR_PEND, 8'h10);
		repeat (2) @(posedge core_clk);
		check("irq pend cleared", 32'h0, 32'(irqOut));
		rd(`UST_ADDR_PEND, 32'h00, "pend cleared");
	endtask
	initial begin
		rst = 1'b1;
		oscIn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h000000000000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		repeat (2) @(posedge core_clk);
		t_reset();
		t_regs();
		t_clock();
		t_tx_idle();
		t_tx_busy();
		t_cts();
		t_rx();
		t_modem();
		stop_test();
	end
endmodule
